// File: core/osd_page_defs.vh
// Constants for the on-screen-display character page generator
// Overview of operation
// - 256 glyphs, 8-bit code addresses glyph store
// - Controller writes codes; rows displayed as window
// - Rows any length; enhanced limits past 32
// - Page memory holds 512 entries including terminators
// - Controller sets page width and height
// - Controller sets horizontal and vertical start
// - Nine-bit colour code, three bits per channel
// - Palette picks 4 of 8 levels per channel
// - Two-bit gain field scales output four steps
// - Vertical flyback synchronizes display and blanks video
// - Fourth bias converter offsets the other three
// - Gain field sits at configuration bits 4:3
// - Device answers write address byte 0xBA
`ifndef OSD_PAGE_DEFS_VH
`define OSD_PAGE_DEFS_VH
`define PAGE_DEPTH        512
`define PAGE_AW           9
`define ROW_END_CODE      8'hff
`define ENH_ROW_LIMIT     32
`define GAIN_LSB          3
`define GAIN_MSB          4
`define SLAVE_WRITE_ADDR  8'hba
`define CELL_W            12
`define CELL_H            18
`define FIFO_DEPTH        16
`endif

// File: core/osd_pixel_fifo.v
// Parameterised pixel FIFO between page generator and output stage
`timescale 1ns/100ps
module osd_pixel_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 16,
	parameter AW    = 4
)(
	// Clock and reset
	input  wire             clk,
	input  wire             reset,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_r;
	reg [AW-1:0]    rd_ptr_r;
	reg [AW:0]      count_r;
	wire            push;
	wire            pop;

	// Honest full and empty from the count
	assign in_ready  = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage write
	always @(posedge clk)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

	// Pointers and count
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push & ~pop)
				count_r <= count_r + 1'b1;
			else if (pop & ~push)
				count_r <= count_r - 1'b1;
		end
	end

	// Head of queue read straight from storage
	always @*
	begin
		out_data = mem_r[rd_ptr_r];
	end
endmodule // osd_pixel_fifo

// File: core/osd_page_gen.v
// Character page generator: page memory, glyph fetch, palette, gain
`timescale 1ns/100ps
`include "osd_page_defs.vh"
module osd_page_gen #(
	parameter PAGE_AW = `PAGE_AW
)(
	// Clock and reset
	input  wire        CLK,
	input  wire        RESET,
	// Page memory write port from the serial bus decoder
	input  wire [7:0]  BUS_DEV_ADDR,
	input  wire        PAGE_WR,
	input  wire [8:0]  PAGE_ADDR,
	input  wire [7:0]  PAGE_DATA,
	// Page layout
	input  wire [5:0]  PAGE_COLS,
	input  wire [4:0]  PAGE_ROWS,
	input  wire [10:0] H_START,
	input  wire [10:0] V_START,
	// Palette: per channel four of eight levels, 3 bits each
	input  wire [11:0] PAL_RED,
	input  wire [11:0] PAL_GREEN,
	input  wire [11:0] PAL_BLUE,
	// Configuration register with gain field
	input  wire [7:0]  CONFIG_REG,
	// PLL settings passed through for the loop
	input  wire [1:0]  PLL_RATE,
	input  wire [2:0]  PIXELS_PER_LINE_SELECT,
	output reg  [4:0]  PLL_SETTING,
	// Bias converters
	input  wire [7:0]  BIAS1,
	input  wire [7:0]  BIAS2,
	input  wire [7:0]  BIAS3,
	input  wire [7:0]  BIAS4,
	input  wire        BRIGHT_MODE,
	output reg  [7:0]  BIAS1_OUT,
	output reg  [7:0]  BIAS2_OUT,
	output reg  [7:0]  BIAS3_OUT,
	output reg  [7:0]  BIAS4_OUT,
	// Sync inputs from pins
	input  wire        V_FLYBACK,
	input  wire        H_FLYBACK,
	// Glyph store lookup
	output reg  [7:0]  GLYPH_CODE,
	output reg  [4:0]  GLYPH_LINE,
	input  wire [11:0] GLYPH_BITS,
	// Pixel output
	output reg  [8:0]  PIX_RGB,
	output reg  [1:0]  PIX_GAIN,
	output reg         PIX_VALID,
	output reg         V_BLANK,
	output wire        ENH_ALLOWED,
	input  wire        PIX_READY
);
	reg  [7:0]  page_mem_r [0:`PAGE_DEPTH-1];
	reg  [2:0]  vf_sync_r;
	reg  [2:0]  hf_sync_r;
	reg  [10:0] hcnt_r;
	reg  [10:0] vcnt_r;
	reg  [PAGE_AW-1:0] rd_ptr_r;
	reg  [PAGE_AW-1:0] row_base_r;
	reg  [5:0]  col_r;
	reg  [4:0]  row_r;
	reg  [3:0]  px_r;
	reg  [4:0]  line_r;
	reg  [11:0] bits_r;
	reg         active_r;
	reg         row_done_r;
	wire        v_edge;
	wire        h_edge;
	wire        in_window;
	wire [7:0]  code;
	wire [1:0]  gain_nxt;
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire [8:0]  fifo_out_data;
	reg  [8:0]  colour_nxt;
	wire [8:0]  bias1_sum;
	wire [8:0]  bias2_sum;
	wire [8:0]  bias3_sum;

	// Pick one of four programmed levels for a channel
	function [2:0] pal_pick;
		input [11:0] pal;
		input [1:0]  sel;
		begin
			pal_pick = pal[sel*3 +: 3];
		end
	endfunction

	// Page writes only when addressed with our device write byte
	always @(posedge CLK)
	begin
		if (PAGE_WR && BUS_DEV_ADDR == `SLAVE_WRITE_ADDR && PAGE_ADDR < `PAGE_DEPTH)
			page_mem_r[PAGE_ADDR] <= PAGE_DATA;
	end

	// Two-flop synchronisers plus edge history
	always @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			vf_sync_r <= 3'h0;
			hf_sync_r <= 3'h0;
		end
		else
		begin
			vf_sync_r <= {vf_sync_r[1:0], V_FLYBACK};
			hf_sync_r <= {hf_sync_r[1:0], H_FLYBACK};
		end
	end
	assign v_edge = vf_sync_r[1] & ~vf_sync_r[2];
	assign h_edge = hf_sync_r[1] & ~hf_sync_r[2];

	assign code        = page_mem_r[rd_ptr_r];
	assign in_window   = (hcnt_r >= H_START) && (vcnt_r >= V_START) && (row_r < PAGE_ROWS);
	assign gain_nxt    = CONFIG_REG[`GAIN_MSB:`GAIN_LSB];
	assign ENH_ALLOWED = (col_r < `ENH_ROW_LIMIT);

	// Brightness sums keep the carry so saturation sees the overflow
	assign bias1_sum = {1'b0, BIAS1} + {1'b0, BIAS4};
	assign bias2_sum = {1'b0, BIAS2} + {1'b0, BIAS4};
	assign bias3_sum = {1'b0, BIAS3} + {1'b0, BIAS4};

	// Raster counters, character walk and pixel serializer
	always @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			hcnt_r     <= 11'h000;
			vcnt_r     <= 11'h000;
			rd_ptr_r   <= {PAGE_AW{1'b0}};
			row_base_r <= {PAGE_AW{1'b0}};
			col_r      <= 6'h00;
			row_r      <= 5'h00;
			px_r       <= 4'h0;
			line_r     <= 5'h00;
			bits_r     <= 12'h000;
			active_r   <= 1'b0;
			row_done_r <= 1'b0;
			V_BLANK    <= 1'b0;
		end
		else if (v_edge)
		begin
			// Frame restarts at top of page
			vcnt_r     <= 11'h000;
			hcnt_r     <= 11'h000;
			rd_ptr_r   <= {PAGE_AW{1'b0}};
			row_base_r <= {PAGE_AW{1'b0}};
			row_r      <= 5'h00;
			line_r     <= 5'h00;
			col_r      <= 6'h00;
			px_r       <= 4'h0;
			active_r   <= 1'b0;
			row_done_r <= 1'b0;
			V_BLANK    <= 1'b1;
		end
		else if (h_edge)
		begin
			// New scan line: back to row start at horizontal start
			hcnt_r     <= 11'h000;
			vcnt_r     <= vcnt_r + 11'h001;
			col_r      <= 6'h00;
			px_r       <= 4'h0;
			active_r   <= 1'b0;
			row_done_r <= 1'b0;
			if (vcnt_r >= V_START)
				V_BLANK <= 1'b0;
			if (vcnt_r >= V_START && line_r == `CELL_H - 1)
			begin
				line_r     <= 5'h00;
				row_r      <= row_r + 5'h01;
				row_base_r <= rd_ptr_r;
			end
			else
			begin
				if (vcnt_r >= V_START)
					line_r <= line_r + 5'h01;
				rd_ptr_r <= row_base_r;
			end
		end
		else if (fifo_in_ready)
		begin
			hcnt_r <= hcnt_r + 11'h001;
			if (in_window && !row_done_r)
			begin
				if (!active_r || px_r == `CELL_W - 1)
				begin
					if (code == `ROW_END_CODE || col_r == PAGE_COLS)
					begin
						row_done_r <= 1'b1;
						active_r   <= 1'b0;
						if (code == `ROW_END_CODE)
							rd_ptr_r <= rd_ptr_r + 1'b1;
					end
					else
					begin
						bits_r   <= GLYPH_BITS;
						rd_ptr_r <= rd_ptr_r + 1'b1;
						col_r    <= col_r + 6'h01;
						active_r <= 1'b1;
						px_r     <= 4'h0;
					end
				end
				else
					px_r <= px_r + 4'h1;
			end
			else
				active_r <= 1'b0;
		end
	end

	// Glyph addressed straight by character code
	always @*
	begin
		GLYPH_CODE = code;
		GLYPH_LINE = line_r;
	end

	// Palette lookup: one glyph bit per pixel picks level 0 or level 2 per channel
	always @*
	begin
		colour_nxt = 9'h000;
		if (active_r)
			colour_nxt = {pal_pick(PAL_RED, {bits_r[11 - px_r], 1'b0}),
				pal_pick(PAL_GREEN, {bits_r[11 - px_r], 1'b0}),
				pal_pick(PAL_BLUE, {bits_r[11 - px_r], 1'b0})};
	end

	osd_pixel_fifo #(
		.WIDTH (9),
		.DEPTH (`FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.clk       (CLK),
		.reset     (RESET),
		.in_valid  (active_r & ~V_BLANK),
		.in_ready  (fifo_in_ready),
		.in_data   (colour_nxt),
		.out_valid (fifo_out_valid),
		.out_ready (PIX_READY),
		.out_data  (fifo_out_data)
	);

	// Registered outputs: pixel, gain, bias, PLL setting
	always @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			PIX_RGB     <= 9'h000;
			PIX_VALID   <= 1'b0;
			PIX_GAIN    <= 2'h0;
			BIAS1_OUT   <= 8'h00;
			BIAS2_OUT   <= 8'h00;
			BIAS3_OUT   <= 8'h00;
			BIAS4_OUT   <= 8'h00;
			PLL_SETTING <= 5'h00;
		end
		else
		begin
			PIX_VALID   <= fifo_out_valid & PIX_READY;
			// Pixel word stands until the next pop
			if (fifo_out_valid & PIX_READY)
				PIX_RGB <= fifo_out_data;
			PIX_GAIN    <= gain_nxt;
			PLL_SETTING <= {PLL_RATE, PIXELS_PER_LINE_SELECT};
			BIAS4_OUT   <= BIAS4;
			if (BRIGHT_MODE)
			begin
				BIAS1_OUT <= bias1_sum[8] ? 8'hff : bias1_sum[7:0];
				BIAS2_OUT <= bias2_sum[8] ? 8'hff : bias2_sum[7:0];
				BIAS3_OUT <= bias3_sum[8] ? 8'hff : bias3_sum[7:0];
			end
			else
			begin
				BIAS1_OUT <= BIAS1;
				BIAS2_OUT <= BIAS2;
				BIAS3_OUT <= BIAS3;
			end
		end
	end
endmodule // osd_page_gen

// File: tb/osd_glyph_store.sv
// Behavioural glyph store that answers the generator's lookups
`timescale 1ns/100ps
module osd_glyph_store (
	// Lookup from the generator
	input  wire [7:0]  code,
	input  wire [4:0]  line,
	// Pixel row answered in the same cycle
	output wire [11:0] bits
);
	// Every 8-bit code selects its own row pattern, so wrong codes show up;
	// the leftmost pixels follow the upper code bits, so both palette levels appear
	assign bits = {code[7:2], ~code[5:0]} ^ {7'h00, line};
endmodule // osd_glyph_store

// File: tb/osd_page_gen_checker.sv
// Concurrent checks on the page generator ports
`timescale 1ns/100ps
module osd_page_gen_checker (
	// Clock and reset
	input wire        CLK,
	input wire        RESET,
	// Watched inputs
	input wire [7:0]  CONFIG_REG,
	input wire [1:0]  PLL_RATE,
	input wire [2:0]  PIXELS_PER_LINE_SELECT,
	input wire [7:0]  BIAS1,
	input wire [7:0]  BIAS4,
	input wire        BRIGHT_MODE,
	input wire [11:0] PAL_RED,
	input wire        V_FLYBACK,
	input wire        PIX_READY,
	// Watched outputs
	input wire [4:0]  PLL_SETTING,
	input wire [7:0]  BIAS1_OUT,
	input wire [8:0]  PIX_RGB,
	input wire [1:0]  PIX_GAIN,
	input wire        PIX_VALID,
	input wire        V_BLANK
);
	// Expected sources of the registered outputs
	wire [4:0] pll_in  = {PLL_RATE, PIXELS_PER_LINE_SELECT};
	wire [8:0] sum1    = {1'b0, BIAS1} + {1'b0, BIAS4};
	wire [7:0] sat1    = sum1[8] ? 8'hff : sum1[7:0];
	wire [1:0] gain_in = CONFIG_REG[4:3];
	wire [2:0] red     = PIX_RGB[8:6];
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RESET);
	a_reset_clear: assert property ($fell(RESET) |-> !PIX_VALID && !V_BLANK && PLL_SETTING == 5'h00)
		else $error("outputs not clear after reset");
	a_pll_follow: assert property (1'b1 |=> PLL_SETTING == $past(pll_in))
		else $error("loop setting does not follow fields");
	a_bias_mix: assert property (BRIGHT_MODE |=> BIAS1_OUT == $past(sat1))
		else $error("brightness offset wrong");
	a_bias_plain: assert property (!BRIGHT_MODE |=> BIAS1_OUT == $past(BIAS1))
		else $error("plain bias wrong");
	a_gain_field: assert property (PIX_VALID && $stable(gain_in) |-> PIX_GAIN == gain_in)
		else $error("gain not from config bits");
	a_palette_level: assert property (PIX_VALID && $stable(PAL_RED) |-> red == PAL_RED[2:0] || red == PAL_RED[8:6])
		else $error("red level not from palette");
	a_stall_hold: assert property (!PIX_READY |=> !PIX_VALID)
		else $error("pixel while stalled");
	a_vblank_rise: assert property ($rose(V_FLYBACK) |-> ##[2:6] V_BLANK)
		else $error("no blank after flyback");
endmodule // osd_page_gen_checker
bind osd_page_gen osd_page_gen_checker chk_i (.CLK(CLK), .RESET(RESET), .CONFIG_REG(CONFIG_REG),
	.PLL_RATE(PLL_RATE), .PIXELS_PER_LINE_SELECT(PIXELS_PER_LINE_SELECT), .BIAS1(BIAS1), .BIAS4(BIAS4),
	.BRIGHT_MODE(BRIGHT_MODE), .PAL_RED(PAL_RED), .V_FLYBACK(V_FLYBACK), .PIX_READY(PIX_READY),
	.PLL_SETTING(PLL_SETTING), .BIAS1_OUT(BIAS1_OUT), .PIX_RGB(PIX_RGB), .PIX_GAIN(PIX_GAIN),
	.PIX_VALID(PIX_VALID), .V_BLANK(V_BLANK));

// File: tb/osd_page_gen_bench.sv
// Self-checking bench for the character page generator
`timescale 1ns/100ps
module osd_page_gen_bench;
	reg         CLK = 0;
	reg         RESET = 1;
	reg  [7:0]  dev = 8'hba, pd = 0, cfg = 8'h10, b1 = 0, b2 = 0, b4 = 0;
	reg         pwr = 0, bm = 0, vf = 0, hf = 0, rdy = 0, hrun = 0, s_ok = 0, s_bad = 0;
	reg  [8:0]  pa = 0;
	reg  [1:0]  rate = 0;
	reg  [2:0]  pixels_per_line_select = 0;
	reg  [5:0]  cols = 6'h04;
	reg  [4:0]  rows = 5'h02;
	reg  [10:0] hs = 11'h004, vs = 11'h002;
	reg  [11:0] pr = 12'h0a1, pg = 12'h1d3, pb = 12'h9e5;
	wire [4:0]  pll, gl;
	wire [7:0]  o1, o2, o3, o4, gc;
	wire [11:0] gb;
	wire [8:0]  rgb;
	wire [1:0]  gain;
	wire        pv, vb, enh;
	integer     num_errors = 0, num_checks = 0, i;
	always #25 CLK = ~CLK;
	// Line flyback runs at 400 ns only while a frame is shown
	always #200 hf = hrun & ~hf;
	// Note which codes reach the glyph lookup
	always @(posedge CLK)
	begin
		if (gc === 8'h41) s_ok <= 1;
		if (gc === 8'h5a) s_bad <= 1;
	end
	osd_page_gen dut (.CLK(CLK), .RESET(RESET), .BUS_DEV_ADDR(dev), .PAGE_WR(pwr), .PAGE_ADDR(pa),
		.PAGE_DATA(pd), .PAGE_COLS(cols), .PAGE_ROWS(rows), .H_START(hs), .V_START(vs), .PAL_RED(pr),
		.PAL_GREEN(pg), .PAL_BLUE(pb), .CONFIG_REG(cfg), .PLL_RATE(rate), .PIXELS_PER_LINE_SELECT(pixels_per_line_select),
		.PLL_SETTING(pll), .BIAS1(b1), .BIAS2(b2), .BIAS3(b2), .BIAS4(b4), .BRIGHT_MODE(bm), .BIAS1_OUT(o1),
		.BIAS2_OUT(o2), .BIAS3_OUT(o3), .BIAS4_OUT(o4), .V_FLYBACK(vf), .H_FLYBACK(hf), .GLYPH_CODE(gc),
		.GLYPH_LINE(gl), .GLYPH_BITS(gb), .PIX_RGB(rgb), .PIX_GAIN(gain), .PIX_VALID(pv), .V_BLANK(vb),
		.ENH_ALLOWED(enh), .PIX_READY(rdy));
	osd_glyph_store store (.code(gc), .line(gl), .bits(gb));
	// Compare and count
	task chk(input [15:0] got, input [15:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	end
	endtask
	function okl(input [2:0] c, input [11:0] p);
		okl = (c === p[2:0]) || (c === p[8:6]);
	endfunction
	task final_report;
	begin
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	// Outputs quiet right after reset, looked at once settled
	task t_reset;
	begin
		@(negedge CLK);
		chk(pv, 1'b0);
		chk(vb, 1'b0);
		chk(enh, 1'b1);
	end
	endtask
	// Every rate and pixels-per-line pair reaches the loop
	task t_pll;
	begin
		for (i = 0; i < 32; i = i + 1)
		begin
			@(posedge CLK);
			rate <= i[4:3];
			pixels_per_line_select <= i[2:0];
			repeat (2) @(negedge CLK);
			chk(pll, i[4:0]);
		end
	end
	endtask
	// Fourth converter offsets the others, saturating
	task t_bias;
	begin
		@(posedge CLK);
		bm <= 1;
		b1 <= 8'hf0;
		b2 <= 8'h10;
		b4 <= 8'h20;
		repeat (2) @(negedge CLK);
		chk({o1, o2}, 16'hff30);
		chk({o3, o4}, 16'h3020);
		@(posedge CLK);
		bm <= 0;
		repeat (2) @(negedge CLK);
		chk({o1, o3}, 16'hf010);
	end
	endtask
	// Page writes, foreign device byte, terminator, pixels with stall
	task t_page;
	begin
		// Row 0 is a bare terminator, row 1 holds one glyph, then a refused write
		@(posedge CLK);
		pwr <= 1;
		pd <= 8'hff;
		@(posedge CLK);
		pa <= 9'h001;
		pd <= 8'h41;
		@(posedge CLK);
		pa <= 9'h002;
		pd <= 8'hff;
		@(posedge CLK);
		dev <= 8'h12;
		pa <= 9'h000;
		pd <= 8'h5a;
		@(posedge CLK);
		pwr <= 0;
		dev <= 8'hba;
		hrun <= 1;
		vf <= 1;
		repeat (8) @(posedge CLK);
		vf <= 0;
		rdy <= 1;
		@(negedge CLK);
		chk(vb, 1'b1);
		i = 0;
		while (pv !== 1'b1 && i < 4000)
		begin
			@(negedge CLK);
			i = i + 1;
		end
		chk(pv, 1'b1);
		chk(vb, 1'b0);
		chk(gain, 2'h2);
		chk({okl(rgb[8:6], pr), okl(rgb[5:3], pg), okl(rgb[2:0], pb)}, 3'h7);
		// Leftmost glyph bits 0 then 1 pick level 0 then level 2 of each channel
		chk(rgb, 9'h05d);
		@(negedge CLK);
		chk(pv, 1'b1);
		chk(rgb, 9'h0bf);
		@(posedge CLK);
		rdy <= 0;
		repeat (60) @(negedge CLK);
		chk(pv, 1'b0);
		@(posedge CLK);
		rdy <= 1;
		repeat (600) @(posedge CLK);
		chk({s_ok, s_bad}, 2'h2);
		hrun <= 0;
	end
	endtask
	// Watchdog cuts a hang short
	initial
	begin
		#2000000;
		num_errors = num_errors + 1;
		final_report;
	end
	initial
	begin
		repeat (5) @(posedge CLK);
		RESET <= 0;
		@(posedge CLK);
		t_reset;
		t_pll;
		t_bias;
		t_page;
		final_report;
	end
endmodule // osd_page_gen_bench
